// [adcc_chk_sva.sv]
// Checker for the converter control block, ports only.
// Assumes one clock domain with rstn as its reset.
`timescale 1ns/10ps
module adcc_chk
  import adcc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int RES_BITS = 10
) (
  input wire logic                sys_clk,         // Clock
  input wire logic                rstn,            // Reset, low active
  input wire logic [7:0]          reg_addr,        // Address
  input wire logic [7:0]          reg_wdata,       // Write data
  input wire logic                reg_wr,          // Write strobe
  input wire logic                reg_rd,          // Read strobe
  input wire logic [7:0]          reg_rdata,       // Read data
  input wire logic                cmp_hi_async,    // Comparator
  input wire logic [RES_BITS-1:0] dac_trial,       // Trial word
  input wire logic [2:0]          analog_mux_sel,  // Input select
  input wire logic [7:0]          port_analog_en,  // Analog pins
  input wire logic                conv_power_on,   // Power
  input wire logic                adc_irq          // Interrupt
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic wr_ctrl;
  logic rd_ctrl;
  logic start_q;

  // Control accesses
  assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  assign rd_ctrl = reg_rd && (reg_addr == ADDR_CTRL);

  // Stored start, so that only a rising start is recognised
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) start_q <= 1'b0;
    else if (wr_ctrl) start_q <= reg_wdata[CTRL_START_BIT];
  end

  // Code 7 is the odd one: all eight pins, not seven
  function automatic logic [7:0] pin_mask(input logic [2:0] code);
    return (code == 3'h7) ? 8'hff : ((8'h01 << code) - 8'h01);
  endfunction

  // Field stored at the write edge, pin outputs registered one edge later
  AST_MUX_SEL: assert property (wr_ctrl
    |-> ##2 analog_mux_sel == $past(reg_wdata[2:0], 2))
    else $error("channel select differs from control write");
  AST_PIN_MASK: assert property (wr_ctrl
    |-> ##2 port_analog_en == pin_mask($past(reg_wdata[5:3], 2)))
    else $error("analog pin set differs from pin code");
  AST_POWER: assert property (wr_ctrl
    |-> ##2 conv_power_on == ($past(reg_wdata[5:3], 2) != 3'h0))
    else $error("converter power differs from pin code");
  AST_LOW_PAD: assert property (reg_rd && reg_addr == ADDR_RESULT_LOW
    |=> reg_rdata[5:0] == 6'h00)
    else $error("low result byte has stray bits");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  AST_UNMAPPED: assert property (reg_rd && (reg_addr < ADDR_RESULT_LOW || reg_addr > ADDR_IRQ_CLR)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CLK_PAD: assert property (reg_rd && reg_addr == ADDR_CLK
    |=> reg_rdata[6:2] == 5'h00)
    else $error("clock register unused bits not zero");
  AST_IRQ_MASK: assert property (reg_wr && reg_addr == ADDR_IRQ_EN && reg_wdata[1:0] == 2'h0
    |-> ##2 (!adc_irq) [*2])
    else $error("interrupt while all enables off");
  AST_BUSY_SET: assert property (wr_ctrl && reg_wdata[CTRL_START_BIT] && !start_q
    ##[1:2] rd_ctrl |=> reg_rdata[CTRL_BUSY_BIT])
    else $error("busy not set by rising start");
endmodule

bind adcc_top adcc_chk #(.CHANNELS(CHANNELS), .RES_BITS(RES_BITS)) i_adcc_chk (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_hi_async(cmp_hi_async),
  .dac_trial(dac_trial), .analog_mux_sel(analog_mux_sel), .port_analog_en(port_analog_en),
  .conv_power_on(conv_power_on), .adc_irq(adc_irq));

// [adcc_pkg.sv]
// Package for the converter control and result block: register map,
// field positions, reset values and clock divider codes.
// Assumes a byte-wide data-memory register port inside the controller.
package adcc_pkg;

  // Register offsets in data memory
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h24;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h25;
  localparam logic [7:0] ADDR_CTRL        = 8'h26;
  localparam logic [7:0] ADDR_CLK         = 8'h27;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h28;
  localparam logic [7:0] ADDR_IRQ_EN      = 8'h29;
  localparam logic [7:0] ADDR_IRQ_CLR     = 8'h2a;

  // Control register fields
  localparam int CTRL_CH_LSB   = 0;
  localparam int CTRL_PIN_LSB  = 3;
  localparam int CTRL_BUSY_BIT = 6;
  localparam int CTRL_START_BIT = 7;

  // Clock select codes, two low bits of the clock register
  localparam logic [1:0] CLK_DIV2  = 2'h0;
  localparam logic [1:0] CLK_DIV8  = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [5:0] DIV2_TC   = 6'h01;
  localparam logic [5:0] DIV8_TC   = 6'h07;
  localparam logic [5:0] DIV32_TC  = 6'h1f;
  localparam int CLK_TEST_BIT = 7;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CLK_RST  = 8'h00;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_START_BIT = 1;
  localparam int IRQ_BITS      = 2;

  // Converter sequencer states, Gray coded along the path
  typedef enum logic [1:0] {
    ADCC_IDLE  = 2'b00,
    ADCC_ARMED = 2'b01,
    ADCC_CONV  = 2'b11,
    ADCC_DONE  = 2'b10
  } adcc_state_t;

endpackage

// [adcc_sar.sv]
// Successive approximation sequencer for one 10-bit sample.
// Assumes the analog comparator output is already synchronised and
// that clk_en is a one-cycle pulse at the converter clock rate.
`timescale 1ns/10ps
module adcc_sar #(
  parameter int RES_BITS = 10
) (
  input  wire logic                sys_clk,  // System clock
  input  wire logic                rst_n,    // Synchronised reset, low active
  input  wire logic                clr,      // Abort and clear trial word
  input  wire logic                go,       // Begin a conversion
  input  wire logic                clk_en,   // Converter clock enable
  input  wire logic                cmp_hi,   // Input above trial level
  output logic [RES_BITS-1:0]      trial,    // Trial word to the DAC
  output logic                     done      // One-cycle completion pulse
);
  // Refused at elaboration: the shift mask only serves these widths
  if (RES_BITS < 2 || RES_BITS > 16) begin : g_bad_res_bits
    $error("RES_BITS out of range");
  end

  logic [RES_BITS-1:0] mask_q;
  logic                run_q;

  // One bit decided per converter clock, MSB first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trial  <= '0;
      mask_q <= '0;
      run_q  <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (clr) begin
        trial  <= '0;
        mask_q <= '0;
        run_q  <= 1'b0;
      end else if (go) begin
        mask_q <= {1'b1, {(RES_BITS-1){1'b0}}};
        trial  <= {1'b1, {(RES_BITS-1){1'b0}}};
        run_q  <= 1'b1;
      end else if (run_q && clk_en) begin
        // Keep or drop the bit under test, then try the next one
        trial  <= (cmp_hi ? trial : (trial & ~mask_q)) | (mask_q >> 1);
        mask_q <= mask_q >> 1;
        if (mask_q[0]) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end
      end
    end
  end
endmodule

// [adcc_top.sv]
// Control and result logic of the 8-channel, 10-bit converter.
// Assumes the analog front end supplies a comparator level from its own
// domain, and software reaches the registers through a byte register port.
// Exact samples need the comparator to settle within one converter period.
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int RES_BITS = 10
) (
  input  wire logic        sys_clk,           // System clock, 250 MHz
  input  wire logic        rstn,              // Chip reset, low active, async
  input  wire logic [7:0]  reg_addr,          // Register address
  input  wire logic [7:0]  reg_wdata,         // Write data
  input  wire logic        reg_wr,            // Write strobe
  input  wire logic        reg_rd,            // Read strobe
  output logic      [7:0]  reg_rdata,         // Read data, cycle after strobe
  input  wire logic        cmp_hi_async,      // Comparator level from front end
  output logic [RES_BITS-1:0] dac_trial,      // Trial word to the DAC
  output logic [2:0]       analog_mux_sel,    // Selected analog input
  output logic [7:0]       port_analog_en,    // Port pins in analog mode
  output logic             conv_power_on,     // Converter power enable
  output logic             adc_irq            // Interrupt, high while pending
);
  // Only the documented sizes fit the byte layout and the pin map
  if (CHANNELS != 8) begin : g_bad_channels
    $error("CHANNELS must be 8");
  end
  if (RES_BITS != 10) begin : g_bad_res_bits
    $error("RES_BITS must be 10");
  end

  // Reset release through two flops; assertion stays asynchronous so the
  // outputs drop at once, while release is clean against sys_clk
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Comparator crosses from the analog side, first flop read only by second.
  // With the registered trial word this puts three cycles or more between a
  // trial change and its decision; the divide-by-2 rate is shorter than that,
  // so its samples are coarse and only the slower rates give exact results
  logic cmp_meta_q;
  logic cmp_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta_q <= 1'b0;
      cmp_q      <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_hi_async;
      cmp_q      <= cmp_meta_q;
    end
  end

  // Register-map fields and sequencer state
  logic [2:0]  chan_q;
  logic [2:0]  pin_cfg_q;
  logic        start_q;
  logic        busy_q;
  logic [1:0]  clk_sel_q;
  logic        clk_test_q;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_en_q;
  logic [RES_BITS-1:0] result_q;
  adcc_state_t state_q;

  logic wr_ctrl;
  logic wr_clk;
  logic start_rise;
  logic start_fall;
  logic conv_done;
  logic [RES_BITS-1:0] sar_trial;
  logic [7:0] rdata_d;

  assign wr_ctrl    = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_clk     = reg_wr && (reg_addr == ADDR_CLK);
  assign start_rise = wr_ctrl && !start_q && reg_wdata[CTRL_START_BIT];
  assign start_fall = wr_ctrl && start_q && !reg_wdata[CTRL_START_BIT];

  // Control register: channel, pin code and start bit
  // The busy bit is read-only; a write to its position is dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_q    <= CTRL_RST[CTRL_CH_LSB +: 3];
      pin_cfg_q <= CTRL_RST[CTRL_PIN_LSB +: 3];
      start_q   <= CTRL_RST[CTRL_START_BIT];
    end else if (wr_ctrl) begin
      chan_q    <= reg_wdata[CTRL_CH_LSB +: 3];
      pin_cfg_q <= reg_wdata[CTRL_PIN_LSB +: 3];
      start_q   <= reg_wdata[CTRL_START_BIT];
    end
  end

  // Clock setting register; the test bit is stored but steers nothing
  // A new code takes effect at once; change it only between conversions
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q  <= CLK_RST[1:0];
      clk_test_q <= CLK_RST[CLK_TEST_BIT];
    end else if (wr_clk) begin
      clk_sel_q  <= reg_wdata[1:0];
      clk_test_q <= reg_wdata[CLK_TEST_BIT];
    end
  end

  // Converter clock divider; code 11 is undefined and treated as /32,
  // the slowest rate being the safe guess
  // Realigning at start keeps the conversion time a whole number of periods
  logic [5:0] div_cnt_q;
  logic [5:0] div_tc;
  logic       conv_clk_en;
  always_comb begin
    case (clk_sel_q)
      CLK_DIV2:  div_tc = DIV2_TC;
      CLK_DIV8:  div_tc = DIV8_TC;
      CLK_DIV32: div_tc = DIV32_TC;
      default:   div_tc = DIV32_TC;
    endcase
  end
  assign conv_clk_en = (div_cnt_q >= div_tc);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= '0;
    end else if (conv_clk_en || start_fall) begin
      div_cnt_q <= '0;                 // Phase realigned at each start
    end else begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // Conversion sequencer and busy flag
  // A falling start while the pin code is zero leaves the sequencer armed:
  // the converter is unpowered, so nothing is begun and busy stays set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ADCC_IDLE;
      busy_q  <= 1'b0;
    end else begin
      case (state_q)
        ADCC_IDLE, ADCC_DONE: begin
          if (start_rise) begin
            state_q <= ADCC_ARMED;
            busy_q  <= 1'b1;
          end
        end
        ADCC_ARMED: begin
          if (start_fall && conv_power_on) begin
            state_q <= ADCC_CONV;
          end
        end
        ADCC_CONV: begin
          if (start_rise) begin
            state_q <= ADCC_ARMED;     // Rising edge aborts and re-arms
          end else if (conv_done) begin
            state_q <= ADCC_DONE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ADCC_IDLE;
        end
      endcase
    end
  end

  // Successive approximation engine
  // A rising start clears it at once; the falling start loads the first trial
  adcc_sar #(
    .RES_BITS (RES_BITS)
  ) u_sar (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clr     (start_rise),
    .go      (state_q == ADCC_ARMED && start_fall && conv_power_on),
    .clk_en  (conv_clk_en),
    .cmp_hi  (cmp_q),
    .trial   (sar_trial),
    .done    (conv_done)
  );

  // Result latched only on completion, so byte reads stay coherent
  // An aborted conversion never reaches here, so the last good sample stays
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (conv_done && state_q == ADCC_CONV && !start_rise) begin
      result_q <= sar_trial;
    end
  end

  // Analog routing outputs
  // Registered so every pin-facing output comes straight from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_mux_sel <= '0;
      conv_power_on  <= 1'b0;
      dac_trial      <= '0;
    end else begin
      analog_mux_sel <= chan_q;
      conv_power_on  <= (pin_cfg_q != 3'h0);
      dac_trial      <= sar_trial;
    end
  end

  // Pin code k makes the k lowest port pins analog, except code 7, which
  // turns all eight over; a plain compare would leave the top pin digital
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_pin
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          port_analog_en[gi] <= 1'b0;
        end else begin
          port_analog_en[gi] <= (pin_cfg_q == 3'h7) || (int'(pin_cfg_q) > gi);
        end
      end
    end
  endgenerate

  // Interrupt status: set wins over clear in the same cycle
  // Bit 0 marks a finished sample, bit 1 a conversion that really began
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE_BIT]  = conv_done && state_q == ADCC_CONV && !start_rise;
    irq_set[IRQ_START_BIT] = start_fall && state_q == ADCC_ARMED && conv_power_on;
  end
  assign irq_clr = (reg_wr && reg_addr == ADDR_IRQ_CLR) ? reg_wdata[IRQ_BITS-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= '0;
    end else if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
      irq_en_q <= reg_wdata[IRQ_BITS-1:0];
    end
  end

  // Level interrupt, registered
  // A handler that clears the status sees the level fall one edge after the write edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_irq <= 1'b0;
    end else begin
      adc_irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read mux; unmapped addresses read zero
  // Reads have no side effects, so polling the busy bit is harmless
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      ADDR_RESULT_LOW:  rdata_d = {result_q[1:0], 6'h00};
      ADDR_RESULT_HIGH: rdata_d = result_q[9:2];
      ADDR_CTRL:        rdata_d = {start_q, busy_q, pin_cfg_q, chan_q};
      ADDR_CLK:         rdata_d = {clk_test_q, 5'h00, clk_sel_q};
      ADDR_IRQ_STAT:    rdata_d = {{(8-IRQ_BITS){1'b0}}, irq_stat_q};
      ADDR_IRQ_EN:      rdata_d = {{(8-IRQ_BITS){1'b0}}, irq_en_q};
      default:          rdata_d = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// [adcc_top_tb.sv]
// Testbench: register-port scenarios for the converter control block.
// Assumes the package constants; the comparator is modelled from dac_trial.
`timescale 1ns/10ps
module adcc_top_tb;
  import adcc_pkg::*;

  logic       sys_clk, rstn, reg_wr, reg_rd, cmp_hi_async, conv_power_on, adc_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, port_analog_en, rd_v;
  logic [9:0] dac_trial;
  logic [2:0] analog_mux_sel;
  int         fails, comparisons, n;

  adcc_top i_adcc_top (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_hi_async(cmp_hi_async),
    .dac_trial(dac_trial), .analog_mux_sel(analog_mux_sel),
    .port_analog_en(port_analog_en), .conv_power_on(conv_power_on), .adc_irq(adc_irq));

  // Clock, 4 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Input c sits half a step above {c, 7'h35}: either polarity at equality agrees
  always @(posedge sys_clk) cmp_hi_async <= (dac_trial <= {analog_mux_sel, 7'h35});

  task automatic chk(input string w, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  task automatic rdc(input string w, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(w, rd_v, e);
  endtask

  // Start, poll busy every second cycle, time it, then read high before low
  task automatic conv(input logic [1:0] sel, input logic [2:0] ch, input bit res);
    int         div;
    logic [9:0] lvl;
    div = (sel == CLK_DIV2) ? 2 : (sel == CLK_DIV8) ? 8 : 32;
    lvl = {ch, 7'h35};
    wr(ADDR_CLK, {6'h00, sel});
    wr(ADDR_CTRL, {2'b10, 3'h4, ch});
    rdc("busy set", ADDR_CTRL, {2'b11, 3'h4, ch});
    wr(ADDR_CTRL, {2'b00, 3'h4, ch});
    n = 0;
    do begin
      rd(ADDR_CTRL);
      n++;
    end while (rd_v[CTRL_BUSY_BIT] !== 1'b0 && n < 400);
    chk("busy clear", rd_v, {2'b00, 3'h4, ch});
    chk("conv time", (2 * n >= 10 * div) && (2 * n <= 10 * div + 4), 1'b1);
    if (res) begin
      chk("trial", dac_trial, lvl);
      rdc("result high", ADDR_RESULT_HIGH, lvl[9:2]);
      rdc("result low", ADDR_RESULT_LOW, {lvl[1:0], 6'h00});
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn         = 1'b0;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    fails        = 0;
    comparisons  = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc("ctrl reset", ADDR_CTRL, 8'h00);
    rdc("clk reset", ADDR_CLK, 8'h00);
    rdc("stat reset", ADDR_IRQ_STAT, 8'h00);
    rdc("en reset", ADDR_IRQ_EN, 8'h00);
    rdc("unmapped", 8'h30, 8'h00);
    wr(ADDR_CLK, 8'h87);
    rdc("clk unused", ADDR_CLK, 8'h83);
    // Every pin code with the same channel code
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL, {2'b00, c[2:0], c[2:0]});
      // Field lands at the write edge, the pin outputs one edge later
      @(posedge sys_clk);
      #1 chk("pins", port_analog_en, (c == 7) ? 8'hff : (8'h01 << c) - 8'h01);
      chk("power", conv_power_on, c != 0);
      chk("mux", analog_mux_sel, c[2:0]);
    end
    wr(ADDR_IRQ_EN, 8'h01);
    conv(CLK_DIV8, 3'h0, 1'b1);
    #1 chk("irq raised", adc_irq, 1'b1);
    rd(ADDR_IRQ_STAT);
    chk("irq done", rd_v[IRQ_DONE_BIT], 1'b1);
    chk("irq start", rd_v[IRQ_START_BIT], 1'b1);
    wr(ADDR_IRQ_CLR, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq cleared", adc_irq, 1'b0);
    // Masked; a conversion cut short by a new rising start
    wr(ADDR_IRQ_EN, 8'h00);
    wr(ADDR_CTRL, 8'ha6);
    wr(ADDR_CTRL, 8'h26);
    repeat (20) @(posedge sys_clk);
    rdc("held high", ADDR_RESULT_HIGH, 8'h0d);
    conv(CLK_DIV32, 3'h6, 1'b1);
    chk("irq masked", adc_irq, 1'b0);
    wr(ADDR_IRQ_EN, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq unmasked", adc_irq, 1'b1);
    wr(ADDR_IRQ_EN, 8'h00);
    @(posedge sys_clk);
    #1 chk("irq remasked", adc_irq, 1'b0);
    conv(CLK_DIV2, 3'h5, 1'b0);
    // Reset after the last conversion drops the pin outputs and clears the registers
    @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk);
    #1 chk("rst pins", port_analog_en, 8'h00);
    chk("rst power", conv_power_on, 1'b0);
    chk("rst mux", analog_mux_sel, 3'h0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc("ctrl after rst", ADDR_CTRL, 8'h00);
    rdc("high after rst", ADDR_RESULT_HIGH, 8'h00);
    give_verdict();
  end

  // Watchdog; the tests need about 560 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end
endmodule
